/* File: src/radio_loop_and_amp_config.sv */
`timescale 1ns/1ps
module radio_loop_and_amp_config (
   // Clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 rst_n,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic                      pready,
   output logic [31:0]               prdata,
   output logic                      pslverr,
   // Radio state and receiver events
   input  wire logic                 in_tx_state,
   input  wire logic                 in_rx_state,
   input  wire logic                 preamble_det,
   input  wire logic                 sync_det,
   // Gain control
   output radio_cfg_pkg::gain_state_t gain_state,
   // Amplifier control
   output logic                      amp_output_topology,
   output logic [5:0]                amp_power_fine,
   // Table ROM read port
   output logic                      rom_rd_en,
   output logic [4:0]                rom_addr,
   input  wire logic [7:0]           rom_data,
   // Packet memory read port
   output logic                      pkt_rd_en,
   output logic [7:0]                pkt_addr,
   input  wire logic [7:0]           pkt_data,
   // Synthesizer table load
   output logic                      lut_valid,
   output logic                      lut_is_tx,
   output logic [3:0]                lut_index,
   output logic [7:0]                lut_data
);

   logic [7:0]  gain_loop_q;
   logic [7:0]  amp_q;
   logic [5:0]  tune_a_q;
   logic [5:0]  fine_q;
   logic        qual_q;
   logic        pready_q;
   logic [31:0] prdata_q;
   logic        pslverr_q;
   logic        in_tx_q;
   logic        in_rx_q;
   logic        access;
   logic        done;
   logic        wr_done;
   logic        hit;
   logic [7:0]  rd_byte;
   logic [3:0]  step_wr;
   loop_cfg_if  loop_cfg ();

   // Bus handshake terms; one wait state lets read data leave a flop
   assign access  = psel && penable;
   assign done    = access && pready_q;
   assign wr_done = done && pwrite;
   assign step_wr = pwdata[radio_cfg_pkg::STEP_HI:radio_cfg_pkg::STEP_LO];

   // Address decode and read mux
   always_comb begin
      hit     = 1'b1;
      rd_byte = 8'h00;
      unique case (paddr)
         radio_cfg_pkg::ADDR_RX_TUNE_A: rd_byte = {tune_a_q, 2'b00};
         radio_cfg_pkg::ADDR_GAIN_LOOP: rd_byte = gain_loop_q;
         radio_cfg_pkg::ADDR_AMP:       rd_byte = amp_q;
         radio_cfg_pkg::ADDR_AMP_FINE:  rd_byte = {2'b00, fine_q};
         radio_cfg_pkg::ADDR_STATUS: begin
            rd_byte[radio_cfg_pkg::ST_QUAL_BIT] = qual_q;
            rd_byte[radio_cfg_pkg::ST_LOCK_BIT] = (gain_state == radio_cfg_pkg::GS_LOCKED);
            rd_byte[radio_cfg_pkg::ST_BUSY_BIT] = loop_cfg.busy;
         end
         default: hit = 1'b0;
      endcase
   end

   // APB answer: ready rises in the second access cycle, then drops
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (access && !pready_q) begin
         pready_q  <= 1'b1;
         prdata_q  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
         pslverr_q <= !hit;
      end else begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end
   end

   assign pready  = pready_q;
   assign prdata  = prdata_q;
   assign pslverr = pslverr_q;

   // Gain and loop table configuration; reads have no side effects
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         gain_loop_q <= radio_cfg_pkg::RST_BYTE;
      end else if (wr_done && paddr == radio_cfg_pkg::ADDR_GAIN_LOOP) begin
         gain_loop_q <= pwdata[7:0];
      end
   end

   // Receive tuning field A; low bits belong to another block
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tune_a_q <= radio_cfg_pkg::RST_BYTE[5:0];
      end else if (wr_done && paddr == radio_cfg_pkg::ADDR_RX_TUNE_A) begin
         tune_a_q <= pwdata[radio_cfg_pkg::TUNE_A_HI:radio_cfg_pkg::TUNE_A_LO];
      end
   end

   // Amplifier topology and coarse step, stored whole for read back
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         amp_q <= radio_cfg_pkg::RST_BYTE;
      end else if (wr_done && paddr == radio_cfg_pkg::ADDR_AMP) begin
         amp_q <= pwdata[7:0];
      end
   end

   // Fine power: a coarse write overrides it, a direct write sets any code
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fine_q <= radio_cfg_pkg::RST_FINE;
      end else if (wr_done && paddr == radio_cfg_pkg::ADDR_AMP) begin
         fine_q <= 6'({2'b00, step_wr} * radio_cfg_pkg::FINE_MUL
                      + radio_cfg_pkg::FINE_OFS);
      end else if (wr_done && paddr == radio_cfg_pkg::ADDR_AMP_FINE) begin
         fine_q <= pwdata[radio_cfg_pkg::FINE_W-1:0];
      end
   end

   // Preamble qualifier, kept with the status bits
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         qual_q <= 1'b0;
      end else if (wr_done && paddr == radio_cfg_pkg::ADDR_STATUS) begin
         qual_q <= pwdata[radio_cfg_pkg::ST_QUAL_BIT];
      end
   end

   // Amplifier outputs straight from their flops
   assign amp_output_topology = amp_q[radio_cfg_pkg::TOPO_BIT];
   assign amp_power_fine      = fine_q;

   // Radio state history for entry detection; state comes from the same clock
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_tx_q <= 1'b0;
         in_rx_q <= 1'b0;
      end else begin
         in_tx_q <= in_tx_state;
         in_rx_q <= in_rx_state;
      end
   end

   // Table selection inputs to the fetcher
   assign loop_cfg.src      = gain_loop_q[radio_cfg_pkg::LOOP_SRC_HI:radio_cfg_pkg::LOOP_SRC_LO];
   assign loop_cfg.tune_a   = tune_a_q;
   assign loop_cfg.tune_b   = gain_loop_q[radio_cfg_pkg::TUNE_B_HI:radio_cfg_pkg::TUNE_B_LO];
   assign loop_cfg.enter_tx = in_tx_state && !in_tx_q;
   assign loop_cfg.enter_rx = in_rx_state && !in_rx_q;

   gain_hold_ctrl u_gain (
      .ref_clk      (ref_clk),
      .rst_n        (rst_n),
      .policy       (gain_loop_q[radio_cfg_pkg::GAIN_POL_HI:radio_cfg_pkg::GAIN_POL_LO]),
      .qualifier    (qual_q),
      .in_rx        (in_rx_state),
      .preamble_det (preamble_det),
      .sync_det     (sync_det),
      .gain_state_q (gain_state)
   );

   loop_table_fetch u_fetch (
      .ref_clk     (ref_clk),
      .rst_n       (rst_n),
      .cfg         (loop_cfg.fetcher),
      .rom_rd_en_q (rom_rd_en),
      .rom_addr_q  (rom_addr),
      .rom_data    (rom_data),
      .pkt_rd_en_q (pkt_rd_en),
      .pkt_addr_q  (pkt_addr),
      .pkt_data    (pkt_data),
      .lut_valid_q (lut_valid),
      .lut_is_tx_q (lut_is_tx),
      .lut_index_q (lut_index),
      .lut_data_q  (lut_data)
   );

   a_fine_from_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_done && paddr == radio_cfg_pkg::ADDR_AMP)
      |=> amp_power_fine == {$past(pwdata[6:3]), 2'b11})
      else $error("fine power not four times step plus three");

   a_fine_direct: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_done && paddr == radio_cfg_pkg::ADDR_AMP_FINE)
      |=> amp_power_fine == $past(pwdata[5:0]))
      else $error("fine power write not applied");

   a_read_back: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_done && paddr == radio_cfg_pkg::ADDR_GAIN_LOOP) ##1 (!wr_done)[*2]
      ##1 (access && !pwrite && paddr == radio_cfg_pkg::ADDR_GAIN_LOOP && !pready)
      |=> prdata[7:0] == gain_loop_q)
      else $error("read back differs from written value");

   a_unmapped_err: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (access && !pready && !hit) |=> (pready && pslverr && prdata == 32'h0000_0000))
      else $error("unmapped access not refused");

   a_topology_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_done && paddr == radio_cfg_pkg::ADDR_AMP)
      |=> amp_output_topology == $past(pwdata[7]))
      else $error("topology bit not applied");

   // Bus answer timing; exactly one wait state, ready never lingers
   a_ready_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (access && !pready)
      |=> pready)
      else $error("ready missing after one wait state");

   a_ready_single: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pready
      |=> !pready)
      else $error("ready held too long");

   a_write_zero_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (access && !pready && pwrite)
      |=> prdata == 32'h0000_0000)
      else $error("write answered with data");

   a_read_no_side: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (done && !pwrite)
      |=> ($stable(gain_loop_q) && $stable(amp_q)
           && $stable(fine_q) && $stable(tune_a_q)))
      else $error("read changed a register");

   a_unmapped_no_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_done && !hit)
      |=> ($stable(gain_loop_q) && $stable(amp_q)
           && $stable(fine_q) && $stable(tune_a_q)))
      else $error("unmapped write changed a register");

   a_gain_loop_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_done && paddr == radio_cfg_pkg::ADDR_GAIN_LOOP)
      |=> gain_loop_q == $past(pwdata[7:0]))
      else $error("gain and loop byte not stored");

   a_amp_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_done && paddr == radio_cfg_pkg::ADDR_AMP)
      |=> amp_q == $past(pwdata[7:0]))
      else $error("amplifier byte not stored");

   a_tune_a_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_done && paddr == radio_cfg_pkg::ADDR_RX_TUNE_A)
      |=> tune_a_q == $past(pwdata[7:2]))
      else $error("tuning field not stored");

   a_qualifier_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wr_done && paddr == radio_cfg_pkg::ADDR_STATUS)
      |=> qual_q == $past(pwdata[0]))
      else $error("qualifier not stored");

   a_status_lock: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (access && !pready && !pwrite && paddr == radio_cfg_pkg::ADDR_STATUS)
      |=> prdata[1]
          == ($past(gain_state) == radio_cfg_pkg::GS_LOCKED))
      else $error("lock status bit wrong");

   a_lock_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (gain_loop_q[7:6] == 2'b11 && in_rx_state
       && gain_state == radio_cfg_pkg::GS_LOCKED)
      |=> gain_state == radio_cfg_pkg::GS_LOCKED)
      else $error("gain lock lost in receive");

   a_free_outside_rx: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (gain_loop_q[7:6] == 2'b11 && !in_rx_state)
      |=> gain_state == radio_cfg_pkg::GS_FREE)
      else $error("gain not free outside receive");

endmodule

/* File: shared/radio_cfg_pkg.sv */
package radio_cfg_pkg;

   // APB geometry: register indices are word indices, byte address is four times
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] IDX_RX_TUNE_A  = 12'h112;
   localparam logic [ADDR_W-1:0] IDX_GAIN_LOOP  = 12'h113;
   localparam logic [ADDR_W-1:0] IDX_AMP        = 12'h114;
   localparam logic [ADDR_W-1:0] IDX_AMP_FINE   = 12'h307;
   localparam logic [ADDR_W-1:0] IDX_STATUS     = 12'h120;
   localparam logic [ADDR_W-1:0] ADDR_RX_TUNE_A = 12'(IDX_RX_TUNE_A * 4);
   localparam logic [ADDR_W-1:0] ADDR_GAIN_LOOP = 12'(IDX_GAIN_LOOP * 4);
   localparam logic [ADDR_W-1:0] ADDR_AMP       = 12'(IDX_AMP * 4);
   localparam logic [ADDR_W-1:0] ADDR_AMP_FINE  = 12'(IDX_AMP_FINE * 4);
   localparam logic [ADDR_W-1:0] ADDR_STATUS    = 12'(IDX_STATUS * 4);

   // Field positions
   localparam int GAIN_POL_HI = 7;
   localparam int GAIN_POL_LO = 6;
   localparam int LOOP_SRC_HI = 5;
   localparam int LOOP_SRC_LO = 4;
   localparam int TUNE_B_HI   = 3;
   localparam int TUNE_B_LO   = 0;
   localparam int TUNE_A_HI   = 7;
   localparam int TUNE_A_LO   = 2;
   localparam int TOPO_BIT    = 7;
   localparam int STEP_HI     = 6;
   localparam int STEP_LO     = 3;
   localparam int FINE_W      = 6;
   localparam int ST_QUAL_BIT = 0;
   localparam int ST_LOCK_BIT = 1;
   localparam int ST_BUSY_BIT = 2;

   // Coarse to fine power mapping: fine = 4 * step + 3
   localparam logic [FINE_W-1:0] FINE_MUL = 6'h04;
   localparam logic [FINE_W-1:0] FINE_OFS = 6'h03;

   // Reset values
   localparam logic [7:0]        RST_BYTE = 8'h00;
   localparam logic [FINE_W-1:0] RST_FINE = 6'h03;

   // Loop table geometry
   localparam logic [3:0] TBL_LEN      = 4'h9;
   localparam logic [3:0] CUST_LEN     = 4'h2;
   localparam logic [7:0] PKT_TBL_BASE = 8'h10;
   localparam logic [7:0] PKT_TBL_LAST = 8'h18;

   typedef enum logic [1:0] {
      GP_FREE     = 2'b00,
      GP_MANUAL   = 2'b01,
      GP_HOLD     = 2'b10,
      GP_LOCK_DET = 2'b11
   } gain_policy_t;

   typedef enum logic [1:0] {
      GS_FREE   = 2'b00,
      GS_MANUAL = 2'b01,
      GS_HOLD   = 2'b10,
      GS_LOCKED = 2'b11
   } gain_state_t;

   typedef enum logic [1:0] {
      FS_IDLE   = 2'b00,
      FS_FETCH  = 2'b01,
      FS_CUSTOM = 2'b10
   } fetch_state_t;

endpackage

/* File: shared/loop_cfg_if.sv */
`timescale 1ns/1ps
interface loop_cfg_if;
   logic [1:0] src;
   logic [5:0] tune_a;
   logic [3:0] tune_b;
   logic       enter_tx;
   logic       enter_rx;
   logic       busy;

   modport owner   (output src, tune_a, tune_b, enter_tx, enter_rx, input busy);
   modport fetcher (input src, tune_a, tune_b, enter_tx, enter_rx, output busy);
endinterface

/* File: src/gain_hold_ctrl.sv */
`timescale 1ns/1ps
module gain_hold_ctrl (
   // Clock and reset
   input  wire logic                       ref_clk,
   input  wire logic                       rst_n,
   // Configuration
   input  wire logic [1:0]                 policy,
   input  wire logic                       qualifier,
   // Receiver events
   input  wire logic                       in_rx,
   input  wire logic                       preamble_det,
   input  wire logic                       sync_det,
   // Gain control state
   output radio_cfg_pkg::gain_state_t      gain_state_q
);

   radio_cfg_pkg::gain_state_t gain_state_d;

   // Policy decode; the lock mode holds once armed until receive ends
   always_comb begin
      gain_state_d = radio_cfg_pkg::GS_FREE;
      unique case (radio_cfg_pkg::gain_policy_t'(policy))
         radio_cfg_pkg::GP_FREE:   gain_state_d = radio_cfg_pkg::GS_FREE;
         radio_cfg_pkg::GP_MANUAL: gain_state_d = radio_cfg_pkg::GS_MANUAL;
         radio_cfg_pkg::GP_HOLD:   gain_state_d = radio_cfg_pkg::GS_HOLD;
         radio_cfg_pkg::GP_LOCK_DET: begin
            if (!in_rx) begin
               gain_state_d = radio_cfg_pkg::GS_FREE;
            end else if (gain_state_q == radio_cfg_pkg::GS_LOCKED) begin
               gain_state_d = radio_cfg_pkg::GS_LOCKED;
            end else if (preamble_det || (sync_det && !qualifier)) begin
               gain_state_d = radio_cfg_pkg::GS_LOCKED;
            end
         end
      endcase
   end

   // Gain state register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         gain_state_q <= radio_cfg_pkg::GS_FREE;
      end else begin
         gain_state_q <= gain_state_d;
      end
   end

   a_lock_on_preamble: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (policy == 2'b11 && in_rx && preamble_det) |=> gain_state_q == radio_cfg_pkg::GS_LOCKED)
      else $error("gain not locked after preamble");

   a_sync_qualified: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (policy == 2'b11 && in_rx && sync_det && qualifier && !preamble_det
       && gain_state_q != radio_cfg_pkg::GS_LOCKED) |=> gain_state_q == radio_cfg_pkg::GS_FREE)
      else $error("gain locked on sync while qualifier set");

   a_fixed_policy: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (policy == 2'b10) ##1 (policy == 2'b10) |-> gain_state_q == radio_cfg_pkg::GS_HOLD)
      else $error("hold policy not reflected");

endmodule

/* File: src/loop_table_fetch.sv */
`timescale 1ns/1ps
module loop_table_fetch (
   // Clock and reset
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   // Configuration and state entries
   loop_cfg_if.fetcher              cfg,
   // Table ROM read port, data one cycle after enable
   output logic                     rom_rd_en_q,
   output logic [4:0]               rom_addr_q,
   input  wire logic [7:0]          rom_data,
   // Packet memory read port, data one cycle after enable
   output logic                     pkt_rd_en_q,
   output logic [7:0]               pkt_addr_q,
   input  wire logic [7:0]          pkt_data,
   // Synthesizer table load
   output logic                     lut_valid_q,
   output logic                     lut_is_tx_q,
   output logic [3:0]               lut_index_q,
   output logic [7:0]               lut_data_q
);

   radio_cfg_pkg::fetch_state_t state_q;
   logic [3:0] idx_q;
   logic       tx_q;
   logic       from_pkt_q;
   logic [3:0] iss_idx_q;
   logic       iss_tx_q;
   logic       pend_q;
   logic       pend_pkt_q;
   logic       pend_tx_q;
   logic [3:0] pend_idx_q;

   assign cfg.busy = (state_q != radio_cfg_pkg::FS_IDLE) || rom_rd_en_q || pkt_rd_en_q || pend_q;

   // Sequencer; a fresh state entry restarts any load still running
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q    <= radio_cfg_pkg::FS_IDLE;
         idx_q      <= 4'h0;
         tx_q       <= 1'b0;
         from_pkt_q <= 1'b0;
      end else if (cfg.enter_tx) begin
         state_q    <= radio_cfg_pkg::FS_FETCH;
         idx_q      <= 4'h0;
         tx_q       <= 1'b1;
         from_pkt_q <= cfg.src[1];
      end else if (cfg.enter_rx) begin
         state_q    <= cfg.src[0] ? radio_cfg_pkg::FS_CUSTOM
                                  : radio_cfg_pkg::FS_FETCH;
         idx_q      <= 4'h0;
         tx_q       <= 1'b0;
         from_pkt_q <= 1'b0;
      end else begin
         unique case (state_q)
            radio_cfg_pkg::FS_IDLE: ;
            radio_cfg_pkg::FS_FETCH: begin
               idx_q <= idx_q + 4'h1;
               if (idx_q == radio_cfg_pkg::TBL_LEN - 4'h1) begin
                  state_q <= radio_cfg_pkg::FS_IDLE;
               end
            end
            radio_cfg_pkg::FS_CUSTOM: begin
               idx_q <= idx_q + 4'h1;
               if (idx_q == radio_cfg_pkg::CUST_LEN - 4'h1) begin
                  state_q <= radio_cfg_pkg::FS_IDLE;
               end
            end
            default: state_q <= radio_cfg_pkg::FS_IDLE;
         endcase
      end
   end

   // Read issue, then one cycle of memory latency before the load strobe
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rom_rd_en_q <= 1'b0;
         pkt_rd_en_q <= 1'b0;
         rom_addr_q  <= 5'h00;
         pkt_addr_q  <= 8'h00;
         iss_idx_q   <= 4'h0;
         iss_tx_q    <= 1'b0;
         pend_q      <= 1'b0;
         pend_pkt_q  <= 1'b0;
         pend_tx_q   <= 1'b0;
         pend_idx_q  <= 4'h0;
      end else begin
         rom_rd_en_q <= (state_q == radio_cfg_pkg::FS_FETCH) && !from_pkt_q;
         pkt_rd_en_q <= (state_q == radio_cfg_pkg::FS_FETCH) && from_pkt_q;
         rom_addr_q  <= {tx_q, idx_q};
         pkt_addr_q  <= radio_cfg_pkg::PKT_TBL_BASE + {4'h0, idx_q};
         iss_idx_q   <= idx_q;
         iss_tx_q    <= tx_q;
         pend_q      <= rom_rd_en_q || pkt_rd_en_q;
         pend_pkt_q  <= pkt_rd_en_q;
         pend_tx_q   <= iss_tx_q;
         pend_idx_q  <= iss_idx_q;
      end
   end

   // Load strobe; the custom receive words come straight from the tuning fields
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lut_valid_q <= 1'b0;
         lut_is_tx_q <= 1'b0;
         lut_index_q <= 4'h0;
         lut_data_q  <= 8'h00;
      end else if (state_q == radio_cfg_pkg::FS_CUSTOM) begin
         lut_valid_q <= 1'b1;
         lut_is_tx_q <= 1'b0;
         lut_index_q <= idx_q;
         lut_data_q  <= (idx_q == 4'h0) ? {2'b00, cfg.tune_a}
                                        : {4'h0, cfg.tune_b};
      end else begin
         lut_valid_q <= pend_q;
         lut_is_tx_q <= pend_tx_q;
         lut_index_q <= pend_idx_q;
         lut_data_q  <= pend_pkt_q ? pkt_data : rom_data;
      end
   end

   a_fetch_rom_tx: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (cfg.enter_tx && !cfg.src[1]) |=> ##1 (rom_rd_en_q && rom_addr_q == 5'h10))
      else $error("tx entry did not read ROM table");

   a_fetch_rom_rx: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (cfg.enter_rx && !cfg.src[0]) |=> ##1 (rom_rd_en_q && rom_addr_q == 5'h00))
      else $error("rx entry did not read ROM table");

   a_pkt_window: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pkt_rd_en_q |-> (pkt_addr_q >= 8'h10 && pkt_addr_q <= 8'h18))
      else $error("packet memory read outside table window");

   a_custom_rx_word: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (cfg.enter_rx && cfg.src[0]) |=> ##1 (lut_valid_q && !lut_is_tx_q && lut_index_q == 4'h0)
      ##1 (lut_valid_q && lut_index_q == 4'h1 && lut_data_q == {4'h0, cfg.tune_b}))
      else $error("custom receive table not emitted");

endmodule

/* File: sim/radio_loop_and_amp_config_tb.sv */
`timescale 1ns/1ps
module radio_loop_and_amp_config_tb;
   // Byte addresses of the mapped registers
   localparam logic [11:0] A_GL = radio_cfg_pkg::ADDR_GAIN_LOOP;
   localparam logic [11:0] A_AM = radio_cfg_pkg::ADDR_AMP;
   localparam logic [11:0] A_FN = radio_cfg_pkg::ADDR_AMP_FINE;
   localparam logic [11:0] A_TA = radio_cfg_pkg::ADDR_RX_TUNE_A;
   localparam logic [11:0] A_ST = radio_cfg_pkg::ADDR_STATUS;
   // Stimulus, observed outputs and scoreboard
   logic        ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, err, amp_output_topology, rom_rd_en, pkt_rd_en;
   logic        in_tx_state = 1'b0, in_rx_state = 1'b0, preamble_det = 1'b0, sync_det = 1'b0;
   logic [7:0]  rom_data = 8'h00, pkt_data = 8'h00, pkt_addr, lut_data, v;
   logic [5:0]  amp_power_fine;
   logic [4:0]  rom_addr;
   logic [3:0]  lut_index;
   logic        lut_valid, lut_is_tx;
   radio_cfg_pkg::gain_state_t gain_state;
   logic [12:0] lut_q[$];
   int          n_mismatch = 0, n_compared = 0;

   always #2.5 ref_clk = ~ref_clk;

   radio_loop_and_amp_config dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .in_tx_state(in_tx_state),
      .in_rx_state(in_rx_state), .preamble_det(preamble_det), .sync_det(sync_det),
      .gain_state(gain_state), .amp_output_topology(amp_output_topology),
      .amp_power_fine(amp_power_fine), .rom_rd_en(rom_rd_en), .rom_addr(rom_addr),
      .rom_data(rom_data), .pkt_rd_en(pkt_rd_en), .pkt_addr(pkt_addr), .pkt_data(pkt_data),
      .lut_valid(lut_valid), .lut_is_tx(lut_is_tx), .lut_index(lut_index),
      .lut_data(lut_data));

   // Registered memories; idle cycles toggle so stale data never looks valid
   always @(posedge ref_clk) begin
      rom_data <= rom_rd_en ? {3'h5, rom_addr} : ~rom_data;
      pkt_data <= pkt_rd_en ? (pkt_addr ^ 8'h3C) : ~pkt_data;
      if (lut_valid === 1'b1) lut_q.push_back({lut_is_tx, lut_index, lut_data});
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // One APB transfer; the slave decides when pready comes, bounded wait
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge ref_clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge ref_clk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (i >= 50) begin
         n_mismatch++;
         finish_test();
      end
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, "readback");
   endtask

   task automatic pulse(input logic pre);
      @(posedge ref_clk);
      if (pre) preamble_det <= 1'b1;
      else sync_det <= 1'b1;
      @(posedge ref_clk);
      preamble_det <= 1'b0;
      sync_det     <= 1'b0;
      repeat (2) @(negedge ref_clk);
   endtask

   // Enter a radio state and compare every table word with the expected source
   task automatic load(input logic tx, input logic [1:0] src);
      int n;
      n = (!tx && src[0]) ? 2 : 9;
      apb(1'b1, A_TA, src[0] ? 32'hB4 : 32'h0);
      apb(1'b1, A_GL, {26'h0, src, src[0] ? 4'h9 : 4'h0});
      lut_q.delete();
      if (tx) in_tx_state <= 1'b1;
      else in_rx_state <= 1'b1;
      apb(1'b0, A_ST, 32'h0);
      chk(rd[radio_cfg_pkg::ST_BUSY_BIT], 1'b1, "load busy");
      repeat (16) @(posedge ref_clk);
      in_tx_state <= 1'b0;
      in_rx_state <= 1'b0;
      apb(1'b0, A_ST, 32'h0);
      chk(rd[radio_cfg_pkg::ST_BUSY_BIT], 1'b0, "load idle");
      @(negedge ref_clk);
      chk(lut_q.size(), n, "table length");
      for (int k = 0; k < n; k++) begin
         if (!tx && src[0]) v = (k == 0) ? 8'h2D : 8'h09;
         else if (tx && src[1]) v = 8'(8'h10 + k) ^ 8'h3C;
         else v = {3'h5, tx, 4'(k)};
         chk(lut_q[k], {tx, 4'(k), v}, "table word");
      end
   endtask

   initial begin
      v = 8'($urandom(34236));
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      rchk(A_GL, 32'h0);
      rchk(A_FN, 32'h3);
      // Power step boundaries first, then random bytes with junk above bit 7
      for (int k = 0; k < 10; k++) begin
         v = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
         apb(1'b1, A_AM, {24'($urandom), v});
         rchk(A_AM, v);
         chk(amp_power_fine, 4 * v[6:3] + 3, "fine power");
         chk(amp_output_topology, v[7], "topology");
         apb(1'b1, A_GL, {24'($urandom), v & 8'h3F});
         rchk(A_GL, v & 8'h3F);
      end
      apb(1'b1, A_FN, 32'h2A);
      rchk(A_FN, 32'h2A);
      chk(amp_power_fine, 6'h2A, "fine direct");
      apb(1'b1, 12'h004, 32'hFF);
      chk(err, 1'b1, "unmapped error");
      rchk(A_AM, v);
      // Gain policies
      for (int p = 0; p < 3; p++) begin
         apb(1'b1, A_GL, p << 6);
         repeat (2) @(negedge ref_clk);
         chk(gain_state, p, "gain policy");
      end
      apb(1'b1, A_ST, 32'h1);
      apb(1'b1, A_GL, 32'hC0);
      in_rx_state <= 1'b1;
      pulse(1'b0);
      chk(gain_state == radio_cfg_pkg::GS_LOCKED, 1'b0, "qualified sync");
      pulse(1'b1);
      chk(gain_state, radio_cfg_pkg::GS_LOCKED, "preamble lock");
      apb(1'b0, A_ST, 32'h0);
      chk(rd & 32'h3, 32'h3, "lock status");
      in_rx_state <= 1'b0;
      apb(1'b1, A_ST, 32'h0);
      in_rx_state <= 1'b1;
      pulse(1'b0);
      chk(gain_state, radio_cfg_pkg::GS_LOCKED, "sync lock");
      @(posedge ref_clk);
      in_rx_state <= 1'b0;
      apb(1'b1, A_GL, 32'h0);
      // Every table source in both directions
      for (int s = 0; s < 4; s++) begin
         for (int t = 0; t < 2; t++) begin
            load(t[0], s[1:0]);
         end
      end
      finish_test();
   end
endmodule
